// ### hdl/ubm_pkg.sv
// Purpose: shared constants and carriers for the uhf bank map access gate
// Assumes: word addressing within each bank, 8-bit word address
// Notes: bank codes follow the two-bit air-interface bank field
package ubm_pkg;
    localparam int WA_W = 8;
    localparam logic [1:0] BANK_RSV = 2'h0;
    localparam logic [1:0] BANK_EPC = 2'h1;
    localparam logic [1:0] BANK_TID = 2'h2;
    localparam logic [1:0] BANK_USR = 2'h3;
    // reserved bank
    localparam logic [7:0] RSV_LAST = 8'h03;
    // epc bank
    localparam logic [7:0] EPC_FIRST = 8'h02;
    localparam logic [7:0] EPC_LAST_SMALL = 8'h09;
    localparam logic [7:0] EPC_LAST_LARGE = 8'h0f;
    localparam logic [7:0] EPC_XPC_W1 = 8'h21;
    localparam int EPC_BITS_SMALL = 128;
    localparam int EPC_BITS_LARGE = 224;
    // tid bank
    localparam logic [7:0] TID_LAST = 8'h05;
    // user bank
    localparam logic [7:0] USR_LAST_SMALL = 8'h09;
    localparam logic [7:0] USR_LAST_LARGE = 8'h03;
    localparam int USR_BITS_SMALL = 160;
    localparam int USR_BITS_LARGE = 64;
    localparam logic [7:0] PROX_FIRST = 8'h20;
    localparam logic [7:0] PROX_LAST = 8'hff;

    typedef enum logic [3:0] {
        UBM_TGT_NONE = 4'h1,
        UBM_TGT_UHF = 4'h2,
        UBM_TGT_PROX = 4'h4,
        UBM_TGT_CALC = 4'h8
    } ubm_tgt_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] bank;
        logic [WA_W-1:0] addr;
    } ubm_req_s;

    typedef struct packed {
        logic user_pwd_ok;
        logic user_locked;
        logic user_hidden;
        logic prox_rd_ok;
        logic prox_wr_ok;
    } ubm_perm_s;

    typedef struct packed {
        logic valid;
        logic grant;
        ubm_tgt_e target;
        logic [WA_W-1:0] word;
        logic hidden;
    } ubm_rsp_s;
endpackage

// ### hdl/ubm_decode.sv
// Purpose: combinational bank and word decode per encoding configuration
// Assumes: large_i selects the large encoding map
// Notes: no permission checks here; the gate applies them
module ubm_decode
    import ubm_pkg::*;
(
    // request
    input wire ubm_req_s req_i,
    input wire logic large_i,
    // decode result
    output ubm_tgt_e target_o,
    output logic writable_o,
    output logic [WA_W-1:0] word_o
);
    logic [7:0] epc_last;
    logic [7:0] usr_last;

    always_comb begin
        epc_last = large_i ? EPC_LAST_LARGE : EPC_LAST_SMALL;
        usr_last = large_i ? USR_LAST_LARGE : USR_LAST_SMALL;
        target_o = UBM_TGT_NONE;
        writable_o = 1'b0;
        word_o = req_i.addr;
        unique case (req_i.bank)
            BANK_RSV: begin
                if (req_i.addr <= RSV_LAST) begin
                    target_o = UBM_TGT_UHF;
                    writable_o = 1'b1;
                end
            end
            BANK_EPC: begin
                if (req_i.addr < EPC_FIRST) begin
                    target_o = UBM_TGT_CALC;
                    writable_o = 1'b1;
                end else if (req_i.addr <= epc_last) begin
                    target_o = UBM_TGT_UHF;
                    writable_o = 1'b1;
                end else if (req_i.addr == EPC_XPC_W1) begin
                    target_o = UBM_TGT_CALC;
                    writable_o = 1'b1;
                end
            end
            BANK_TID: begin
                if (req_i.addr <= TID_LAST) begin
                    target_o = UBM_TGT_UHF;
                end
            end
            BANK_USR: begin
                if (req_i.addr <= usr_last) begin
                    target_o = UBM_TGT_UHF;
                    writable_o = 1'b1;
                end else if (req_i.addr >= PROX_FIRST) begin
                    target_o = UBM_TGT_PROX;
                    writable_o = 1'b1;
                    word_o = req_i.addr - PROX_FIRST;
                end
            end
        endcase
    end
endmodule

// ### hdl/ubm_gate.sv
// Purpose: access gate for the four uhf memory banks with proximity memory mapping
// Assumes: reader front end presents one decoded request per valid cycle
// Notes: answer appears one cycle after the request
module ubm_gate
    import ubm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic large_i,
    // request and permissions
    input wire ubm_req_s req_i,
    input wire ubm_perm_s perm_i,
    // answer
    output ubm_rsp_s rsp_o
);
    ubm_tgt_e dec_tgt;
    logic dec_wr;
    logic [WA_W-1:0] dec_word;
    logic allow;
    logic hide;
    ubm_rsp_s rsp_reg;

    // word width of every bank; the storage sizes count in bits, the decode ranges in these words
    localparam int WORD_BITS = 16;
    localparam int EPC_SMALL_WORDS = int'(EPC_LAST_SMALL) - int'(EPC_FIRST) + 1;
    localparam int EPC_LARGE_WORDS = int'(EPC_LAST_LARGE) - int'(EPC_FIRST) + 1;
    localparam int USR_SMALL_WORDS = int'(USR_LAST_SMALL) + 1;
    localparam int USR_LARGE_WORDS = int'(USR_LAST_LARGE) + 1;

    // a decode range that drifts from its storage size would silently lose words
    if (EPC_SMALL_WORDS * WORD_BITS != EPC_BITS_SMALL) begin : g_bad_epc_small
        $error("small map identifier words do not match its size");
    end
    if (USR_SMALL_WORDS * WORD_BITS != USR_BITS_SMALL) begin : g_bad_usr_small
        $error("small map user words do not match its size");
    end
    if (EPC_LARGE_WORDS * WORD_BITS != EPC_BITS_LARGE) begin : g_bad_epc_large
        $error("large map identifier words do not match its size");
    end
    if (USR_LARGE_WORDS * WORD_BITS != USR_BITS_LARGE) begin : g_bad_usr_large
        $error("large map user words do not match its size");
    end
    if (PROX_FIRST <= USR_LAST_SMALL || PROX_FIRST <= USR_LAST_LARGE) begin : g_prox_low
        $error("mapped window overlaps local user words");
    end
    if (int'(PROX_LAST) != (1 << WA_W) - 1) begin : g_prox_high
        $error("mapped window does not reach the last word");
    end
    if (EPC_XPC_W1 <= EPC_LAST_SMALL || EPC_XPC_W1 <= EPC_LAST_LARGE) begin : g_xpc_low
        $error("control word falls inside an identifier range");
    end

    ubm_decode u_dec (
        .req_i(req_i),
        .large_i(large_i),
        .target_o(dec_tgt),
        .writable_o(dec_wr),
        .word_o(dec_word)
    );

    // user bank rules apply to both local and mapped words
    always_comb begin
        hide = (req_i.bank == BANK_USR) && perm_i.user_hidden;
        allow = (dec_tgt != UBM_TGT_NONE) && (dec_wr || !req_i.write) && !hide;
        if (req_i.bank == BANK_USR) begin
            allow = allow && perm_i.user_pwd_ok && !(req_i.write && perm_i.user_locked);
        end
        if (dec_tgt == UBM_TGT_PROX) begin
            allow = allow && (req_i.write ? perm_i.prox_wr_ok : perm_i.prox_rd_ok);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsp_reg <= '{valid: 1'b0, grant: 1'b0, target: UBM_TGT_NONE,
                         word: '0, hidden: 1'b0};
        end else begin
            rsp_reg.valid <= req_i.valid;
            rsp_reg.grant <= req_i.valid && allow;
            rsp_reg.target <= req_i.valid ? dec_tgt : UBM_TGT_NONE;
            rsp_reg.word <= dec_word;
            rsp_reg.hidden <= req_i.valid && hide;
        end
    end

    assign rsp_o = rsp_reg;

    sequence s_prox_req;
        req_i.valid && req_i.bank == BANK_USR && req_i.addr >= PROX_FIRST;
    endsequence

    AST_PROX_MAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prox_req |=> rsp_o.target == UBM_TGT_PROX
            && rsp_o.word == $past(req_i.addr) - PROX_FIRST)
        else $error("mapped user word not routed to proximity memory");
    AST_PROX_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prox_req and (req_i.write && !perm_i.prox_wr_ok) |=> !rsp_o.grant)
        else $error("proximity write granted against lock bytes");
    AST_USER_PWD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && req_i.bank == BANK_USR && !perm_i.user_pwd_ok |=> !rsp_o.grant)
        else $error("user access granted without password");
    AST_HIDDEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prox_req and perm_i.user_hidden |=> rsp_o.hidden && !rsp_o.grant)
        else $error("hidden mapped word was exposed");
    AST_XPC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && req_i.bank == BANK_EPC && req_i.addr == EPC_XPC_W1
            |=> rsp_o.target == UBM_TGT_CALC)
        else $error("control word not decoded");
    AST_EPC_SMALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && !large_i && req_i.bank == BANK_EPC && req_i.addr == 8'h0a |=> !rsp_o.grant)
        else $error("small map epc word 10 granted");
    AST_EPC_LARGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && large_i && req_i.bank == BANK_EPC && req_i.addr == 8'h10 |=> !rsp_o.grant)
        else $error("large map epc word 16 granted");
    AST_USR_LARGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && large_i && req_i.bank == BANK_USR && req_i.addr == 8'h04
            |=> rsp_o.target == UBM_TGT_NONE)
        else $error("large map user word 4 decoded");
    AST_TID_RO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && req_i.write && req_i.bank == BANK_TID |=> !rsp_o.grant)
        else $error("tid write granted");

    // request classes; each answer is judged one cycle after its request
    sequence s_rsv_req;
        req_i.valid && req_i.bank == BANK_RSV && req_i.addr <= RSV_LAST;
    endsequence
    sequence s_tid_read;
        req_i.valid && !req_i.write && req_i.bank == BANK_TID && req_i.addr <= TID_LAST;
    endsequence
    sequence s_xpc_write;
        req_i.valid && req_i.write && req_i.bank == BANK_EPC && req_i.addr == EPC_XPC_W1;
    endsequence
    sequence s_epc_data_small;
        req_i.valid && !large_i && req_i.bank == BANK_EPC
            && req_i.addr >= EPC_FIRST && req_i.addr <= EPC_LAST_SMALL;
    endsequence
    sequence s_epc_data_large;
        req_i.valid && large_i && req_i.bank == BANK_EPC
            && req_i.addr >= EPC_FIRST && req_i.addr <= EPC_LAST_LARGE;
    endsequence
    sequence s_epc_gap_small;
        req_i.valid && !large_i && req_i.bank == BANK_EPC
            && req_i.addr > EPC_LAST_SMALL && req_i.addr != EPC_XPC_W1;
    endsequence
    sequence s_epc_gap_large;
        req_i.valid && large_i && req_i.bank == BANK_EPC
            && req_i.addr > EPC_LAST_LARGE && req_i.addr != EPC_XPC_W1;
    endsequence
    sequence s_usr_data_small;
        req_i.valid && !large_i && req_i.bank == BANK_USR && req_i.addr <= USR_LAST_SMALL;
    endsequence
    sequence s_usr_data_large;
        req_i.valid && large_i && req_i.bank == BANK_USR && req_i.addr <= USR_LAST_LARGE;
    endsequence
    sequence s_usr_gap_small;
        req_i.valid && !large_i && req_i.bank == BANK_USR
            && req_i.addr > USR_LAST_SMALL && req_i.addr < PROX_FIRST;
    endsequence
    sequence s_usr_gap_large;
        req_i.valid && large_i && req_i.bank == BANK_USR
            && req_i.addr > USR_LAST_LARGE && req_i.addr < PROX_FIRST;
    endsequence
    sequence s_prox_read_ok;
        req_i.valid && !req_i.write && req_i.bank == BANK_USR && req_i.addr >= PROX_FIRST
            && perm_i.user_pwd_ok && !perm_i.user_hidden && perm_i.prox_rd_ok;
    endsequence
    sequence s_prox_rd_denied;
        req_i.valid && !req_i.write && req_i.bank == BANK_USR && req_i.addr >= PROX_FIRST
            && !perm_i.prox_rd_ok;
    endsequence
    sequence s_user_locked_write;
        req_i.valid && req_i.write && req_i.bank == BANK_USR && perm_i.user_locked;
    endsequence
    sequence s_prox_top;
        req_i.valid && req_i.bank == BANK_USR && req_i.addr == PROX_LAST;
    endsequence
    sequence s_uhf_grant;
        rsp_o.valid && rsp_o.grant && rsp_o.target == UBM_TGT_UHF;
    endsequence
    sequence s_unused;
        rsp_o.valid && !rsp_o.grant && rsp_o.target == UBM_TGT_NONE;
    endsequence

    AST_RSV_PWD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_rsv_req |=> s_uhf_grant)
        else $error("password word not served");
    AST_TID_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_tid_read |=> s_uhf_grant)
        else $error("read-only identifier word not served");
    AST_EPC_DATA_SMALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_epc_data_small |=> s_uhf_grant)
        else $error("small map identifier word not served");
    AST_EPC_DATA_LARGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_epc_data_large |=> s_uhf_grant)
        else $error("large map identifier word not served");
    AST_EPC_GAP_SMALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_epc_gap_small |=> s_unused)
        else $error("small map unused epc word decoded");
    AST_EPC_GAP_LARGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_epc_gap_large |=> s_unused)
        else $error("large map unused epc word decoded");
    AST_USR_DATA_SMALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_usr_data_small |=> rsp_o.target == UBM_TGT_UHF)
        else $error("small map user word not decoded");
    AST_USR_DATA_LARGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_usr_data_large |=> rsp_o.target == UBM_TGT_UHF)
        else $error("large map user word not decoded");
    AST_USR_GAP_SMALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_usr_gap_small |=> s_unused)
        else $error("small map unused user word decoded");
    AST_USR_GAP_LARGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_usr_gap_large |=> s_unused)
        else $error("large map unused user word decoded");
    AST_PROX_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prox_read_ok |=> rsp_o.grant && !rsp_o.hidden)
        else $error("permitted mapped read refused");
    AST_PROX_RD_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prox_rd_denied |=> !rsp_o.grant)
        else $error("proximity read granted against lock bytes");
    AST_USER_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_user_locked_write |=> !rsp_o.grant)
        else $error("locked user word written");
    AST_XPC_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_xpc_write |=> rsp_o.grant && rsp_o.target == UBM_TGT_CALC)
        else $error("control word write refused");
    AST_PROX_TOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prox_top |=> rsp_o.word == PROX_LAST - PROX_FIRST)
        else $error("last mapped word misplaced");
    AST_HIDE_USER_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && req_i.bank != BANK_USR |=> !rsp_o.hidden)
        else $error("non-user word reported hidden");
    AST_LOCAL_WORD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i.valid && !(req_i.bank == BANK_USR && req_i.addr >= PROX_FIRST)
            |=> rsp_o.word == $past(req_i.addr))
        else $error("local word address altered");
    AST_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !req_i.valid |=> !rsp_o.valid && !rsp_o.grant && !rsp_o.hidden)
        else $error("answer without a request");
endmodule

// ### tb/ubm_reader_model.sv
// Purpose: uhf reader side that issues one-cycle bank requests
// Assumes: requests are launched at the falling clock edge
// Notes: an idle cycle scrambles the address so stale values never pass
module ubm_reader_model
    import ubm_pkg::*;
(
    input wire logic clk_i,
    output ubm_req_s req_o,
    output ubm_perm_s perm_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_o <= '0;
        perm_o <= '0;
    end
    task automatic send(input ubm_req_s r, input ubm_perm_s p);
        @(negedge clk_i);
        req_o <= r;
        perm_o <= p;
    endtask
    task automatic idle();
        @(negedge clk_i);
        req_o <= {1'b0, ~req_o[10:0]};
    endtask
endmodule

// ### tb/test_ubm_gate.sv
// Purpose: self-checking bench for the uhf bank map access gate
// Assumes: one request per cycle, answer one cycle later
// Notes: hidden answers are compared on valid, grant and hidden only
module test_ubm_gate
    import ubm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic large_i = 1'b0;
    ubm_req_s req;
    ubm_perm_s perm;
    ubm_rsp_s rsp;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'hd24b4eb2;
    ubm_gate i_ubm_gate(.clk_i(clk_i), .rst_n_i(rst_n_i), .large_i(large_i),
        .req_i(req), .perm_i(perm), .rsp_o(rsp));
    ubm_reader_model i_ubm_reader_model(.clk_i(clk_i), .req_o(req), .perm_o(perm));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic ubm_rsp_s exp_rsp(ubm_req_s r, ubm_perm_s p, logic lg);
        ubm_rsp_s e;
        e = '{valid: 1'b1, grant: 1'b0, target: UBM_TGT_NONE, word: r.addr, hidden: 1'b0};
        case (r.bank)
            BANK_RSV: if (r.addr < 8'h04) e.target = UBM_TGT_UHF;
            BANK_EPC: begin
                if (r.addr < 8'h02 || r.addr == 8'h21) e.target = UBM_TGT_CALC;
                else if (r.addr >= 8'h02 && r.addr <= (lg ? 8'h0f : 8'h09)) e.target = UBM_TGT_UHF;
            end
            BANK_TID: if (r.addr < 8'h06) e.target = UBM_TGT_UHF;
            default: begin
                if (r.addr >= 8'h20) e.target = UBM_TGT_PROX;
                else if (r.addr <= (lg ? 8'h03 : 8'h09)) e.target = UBM_TGT_UHF;
            end
        endcase
        if (e.target == UBM_TGT_PROX) e.word = r.addr - 8'h20;
        e.grant = (e.target != UBM_TGT_NONE) && !(r.bank == BANK_TID && r.write);
        if (r.bank == BANK_USR) begin
            e.grant &= p.user_pwd_ok && !(r.write && p.user_locked) && !p.user_hidden;
            e.hidden = p.user_hidden;
        end
        if (e.target == UBM_TGT_PROX) e.grant &= r.write ? p.prox_wr_ok : p.prox_rd_ok;
        return e;
    endfunction
    task automatic chk(string what, ubm_rsp_s e, ubm_rsp_s g, logic [14:0] m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic do_req(ubm_req_s r, ubm_perm_s p, logic lg);
        ubm_rsp_s e;
        e = exp_rsp(r, p, lg);
        i_ubm_reader_model.send(r, p);
        large_i <= lg;
        @(posedge clk_i);
        #1;
        // hidden answers leave target and word open
        chk("rsp", e, rsp, e.hidden ? 15'h6001 : 15'h7fff);
    endtask
    task automatic finish_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        err_total++;
        finish_test();
    end
    initial begin
        ubm_req_s r;
        logic [31:0] x;
        repeat (4) @(negedge clk_i);
        chk("reset", 15'h0200, rsp, 15'h7fff);
        rst_n_i <= 1'b1;
        // full permissions: words 0 to 47 of every bank in both maps, back to back
        for (int k = 0; k < 16 * 48; k++) begin
            r = '{valid: 1'b1, write: k[0], bank: k[2:1], addr: 8'(k >> 4)};
            do_req(r, 5'b10011, k[3]);
        end
        // mid-run reset with a request still standing
        i_ubm_reader_model.send(r, 5'b10011);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("reset", 15'h0200, rsp, 15'h7fff);
        @(negedge clk_i);
        rst_n_i <= 1'b1;
        // edges of the mapped window in both maps
        for (int k = 0; k < 8; k++) begin
            r = '{valid: 1'b1, write: k[0], bank: BANK_USR,
                addr: k[1] ? PROX_LAST : PROX_FIRST};
            do_req(r, 5'b10011, k[2]);
        end
        repeat (3000) begin
            x = rnd();
            r = '{valid: 1'b1, write: x[0], bank: x[2:1],
                addr: x[3] ? x[15:8] : {2'b00, x[13:8]}};
            do_req(r, x[20:16], x[4]);
            if (x[22] && x[23]) begin
                i_ubm_reader_model.idle();
                @(posedge clk_i);
                #1;
                chk("idle", 15'h0200, rsp, 15'h7e01);
            end
        end
        finish_test();
    end
endmodule
